/* File: common/gpld_pkg.sv */
// constants, offsets and types of the 32-pin port core
// assumes a single AHB-Lite slave decoding the low 12 address bits
package gpld_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses within the port window)
	// ----------------------------------------------------------------
	localparam int unsigned AW = 12;
	localparam logic [11:0] OFF_DRIVE = 12'h504;
	localparam logic [11:0] OFF_DRIVE_SET = 12'h508;
	localparam logic [11:0] OFF_DRIVE_CLR = 12'h50c;
	localparam logic [11:0] OFF_SAMPLED = 12'h510;
	localparam logic [11:0] OFF_ORIENT = 12'h514;
	localparam logic [11:0] OFF_ORIENT_SET = 12'h518;
	localparam logic [11:0] OFF_ORIENT_CLR = 12'h51c;
	localparam logic [11:0] OFF_CFG_BASE = 12'h700;
	localparam logic [11:0] OFF_CFG_LAST = 12'h77c;

	// ----------------------------------------------------------------
	// per_pin_config fields and reset values
	// ----------------------------------------------------------------
	localparam int unsigned CFG_DIR_BIT = 0;
	localparam int unsigned CFG_INPUT_BIT = 1;
	localparam logic [31:0] RST_DRIVE = 32'h0000_0000;
	localparam logic [31:0] RST_ORIENT = 32'h0000_0000;
	localparam logic [31:0] RST_SAMPLED = 32'h0000_0000;
	localparam logic [31:0] RST_DISC = 32'hffff_ffff;
	localparam logic [31:0] RST_RDATA = 32'h0000_0000;

	// ----------------------------------------------------------------
	// bus encodings and phases
	// ----------------------------------------------------------------
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;

	typedef enum logic [2:0] {
		GPLD_PH_IDLE = 3'b001,
		GPLD_PH_WRITE = 3'b010,
		GPLD_PH_READ = 3'b100
	} gpld_phase_t;

endpackage

/* File: common/gpld_cfg_if.sv */
// carrier between the port core and its input/config bank
// assumes both ends run on hclk
interface gpld_cfg_if;
	logic we;
	logic [4:0] idx;
	logic wdis;
	logic [31:0] disc;
	logic [31:0] sampled;

	modport core (output we, output idx, output wdis, input disc, input sampled);
	modport bank (input we, input idx, input wdis, output disc, output sampled);
endinterface

/* File: rtl/gpld_in_bank.sv */
// input sampling and input-buffer connect bits of the port
// assumes pin_in is asynchronous to hclk
module gpld_in_bank
	import gpld_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [31:0] pin_in,
	gpld_cfg_if.bank cfg
);

	typedef struct packed {
		logic [31:0] sync1;
		logic [31:0] sync2;
		logic [31:0] sampled;
		logic [31:0] disc;
	} gpld_bank_t;

	gpld_bank_t st_r;
	gpld_bank_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.sync1 = pin_in;
		st_nxt.sync2 = st_r.sync1;
		// disconnected buffer reads low, never the pin
		st_nxt.sampled = st_r.sync2 & ~st_r.disc;
		if (cfg.we) begin
			st_nxt.disc[cfg.idx] = cfg.wdis;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r.sync1 <= RST_SAMPLED;
			st_r.sync2 <= RST_SAMPLED;
			st_r.sampled <= RST_SAMPLED;
			st_r.disc <= RST_DISC;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign cfg.disc = st_r.disc;
	assign cfg.sampled = st_r.sampled;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// judged per pin: the bench never connects every buffer at once
	AST_SAMPLED_FOLLOWS_PIN: assert property (@(posedge hclk) disable iff (!hresetn)
		(st_r.sampled & ~$past(st_r.disc)) == ($past(pin_in, 3) & ~$past(st_r.disc)))
		else $error("sampled level does not follow connected pins");

	AST_DISCONNECTED_READS_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
		(st_r.sampled & $past(st_r.disc)) == 32'h0000_0000)
		else $error("disconnected input shows a level");

endmodule // gpld_in_bank

/* File: rtl/gpld_port.sv */
// 32-pin general purpose port core with AHB-Lite register slave
// assumes hready is this slave's own hreadyout; only word transfers used
// pin_out/pin_oe feed the pad; pin_in comes raw from the pad

module gpld_port
	import gpld_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic [31:0] pin_in,
	output logic [31:0] pin_out,
	output logic [31:0] pin_oe
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		gpld_phase_t ph;
		logic [11:0] addr;
		logic hready;
		logic hresp;
		logic [31:0] rdata;
		logic [31:0] drive;
		logic [31:0] orient;
	} gpld_core_t;

	gpld_core_t st_r;
	gpld_core_t st_nxt;
	gpld_cfg_if cfg ();
	logic accept;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic is_cfg(input logic [11:0] a);
		is_cfg = (a >= OFF_CFG_BASE) && (a <= OFF_CFG_LAST) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic [31:0] read_word(
		input logic [11:0] a,
		input logic [31:0] drive,
		input logic [31:0] orient,
		input logic [31:0] disc,
		input logic [31:0] sampled
	);
		logic [4:0] i;
		i = a[6:2];
		read_word = RST_RDATA;
		unique case (a)
			OFF_DRIVE, OFF_DRIVE_SET, OFF_DRIVE_CLR: read_word = drive;
			OFF_SAMPLED: read_word = sampled;
			OFF_ORIENT, OFF_ORIENT_SET, OFF_ORIENT_CLR: read_word = orient;
			default: begin
				if (is_cfg(a)) begin
					// direction bit read straight from the orientation word
					read_word[CFG_DIR_BIT] = orient[i];
					read_word[CFG_INPUT_BIT] = disc[i];
				end
			end
		endcase
	endfunction

	// ----------------------------------------------------------------
	// bus slave and register update
	// ----------------------------------------------------------------
	assign accept = hsel && (htrans == HTRANS_NONSEQ) && hready;

	always_comb begin
		st_nxt = st_r;
		st_nxt.hresp = HRESP_OKAY;
		cfg.we = 1'b0;
		cfg.idx = st_r.addr[6:2];
		cfg.wdis = hwdata[CFG_INPUT_BIT];
		unique case (st_r.ph)
			GPLD_PH_WRITE: begin
				st_nxt.ph = GPLD_PH_IDLE;
				unique case (st_r.addr)
					OFF_DRIVE: st_nxt.drive = hwdata;
					OFF_DRIVE_SET: st_nxt.drive = st_r.drive | hwdata;
					OFF_DRIVE_CLR: st_nxt.drive = st_r.drive & ~hwdata;
					OFF_ORIENT: st_nxt.orient = hwdata;
					OFF_ORIENT_SET: st_nxt.orient = st_r.orient | hwdata;
					OFF_ORIENT_CLR: st_nxt.orient = st_r.orient & ~hwdata;
					default: begin
						// sampled level and unmapped words ignore writes
						if (is_cfg(st_r.addr)) begin
							st_nxt.orient[st_r.addr[6:2]] = hwdata[CFG_DIR_BIT];
							cfg.we = 1'b1;
						end
					end
				endcase
			end
			GPLD_PH_READ: begin
				// one wait state so a read right after a write sees it
				st_nxt.ph = GPLD_PH_IDLE;
				st_nxt.hready = 1'b1;
				st_nxt.rdata = read_word(st_r.addr, st_r.drive, st_r.orient,
					cfg.disc, cfg.sampled);
			end
			GPLD_PH_IDLE: begin
				st_nxt.ph = GPLD_PH_IDLE;
			end
		endcase
		if (accept) begin
			// upper address bits ignored: window repeats every 4 KiB
			st_nxt.addr = haddr[11:0];
			st_nxt.ph = hwrite ? GPLD_PH_WRITE : GPLD_PH_READ;
			st_nxt.hready = hwrite;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r.ph <= GPLD_PH_IDLE;
			st_r.addr <= 12'h000;
			st_r.hready <= 1'b1;
			st_r.hresp <= HRESP_OKAY;
			st_r.rdata <= RST_RDATA;
			st_r.drive <= RST_DRIVE;
			st_r.orient <= RST_ORIENT;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// input bank
	// ----------------------------------------------------------------
	gpld_in_bank u_bank (
		.hclk(hclk),
		.hresetn(hresetn),
		.pin_in(pin_in),
		.cfg(cfg.bank)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign hreadyout = st_r.hready;
	assign hrdata = st_r.rdata;
	assign hresp = st_r.hresp;
	assign pin_out = st_r.drive;
	assign pin_oe = st_r.orient;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_wr(logic [11:0] off);
		hsel && (htrans == HTRANS_NONSEQ) && hready && hwrite && (haddr[11:0] == off);
	endsequence

	sequence s_rd(logic [11:0] off);
		hsel && (htrans == HTRANS_NONSEQ) && hready && !hwrite && (haddr[11:0] == off);
	endsequence

	sequence s_wr_done(logic [11:0] off);
		s_wr(off) ##1 1'b1;
	endsequence

	AST_DRIVE_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr_done(OFF_DRIVE) |=> (pin_out == $past(hwdata)))
		else $error("drive write did not reach the pins");

	AST_DRIVE_SET: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr_done(OFF_DRIVE_SET) |=> (pin_out == ($past(pin_out) | $past(hwdata))))
		else $error("drive set alias wrong");

	AST_DRIVE_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr_done(OFF_DRIVE_CLR) |=> (pin_out == ($past(pin_out) & ~$past(hwdata))))
		else $error("drive clear alias wrong");

	AST_ORIENT_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr_done(OFF_ORIENT) |=> (pin_oe == $past(hwdata)))
		else $error("orientation write did not reach the enables");

	AST_ORIENT_SET: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr_done(OFF_ORIENT_SET) |=> (pin_oe == ($past(pin_oe) | $past(hwdata))))
		else $error("orientation set alias wrong");

	AST_ORIENT_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr_done(OFF_ORIENT_CLR) |=> (pin_oe == ($past(pin_oe) & ~$past(hwdata))))
		else $error("orientation clear alias wrong");

	AST_DRIVE_ALIAS_READ: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_rd(OFF_DRIVE_SET) or s_rd(OFF_DRIVE_CLR))
		|-> ##1 !hreadyout ##1 (hreadyout && (hrdata == pin_out) && $stable(pin_out)))
		else $error("drive alias read wrong");

	AST_ORIENT_ALIAS_READ: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_rd(OFF_ORIENT_SET) or s_rd(OFF_ORIENT_CLR))
		|-> ##1 !hreadyout ##1 (hreadyout && (hrdata == pin_oe)))
		else $error("orientation alias read wrong");

	AST_CFG_DIR_SHARED: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_wr(OFF_CFG_BASE) or (hsel && (htrans == HTRANS_NONSEQ) && hready && hwrite
		&& is_cfg(haddr[11:0]))) ##1 1'b1
		|=> (pin_oe[$past(st_r.addr[6:2])] == $past(hwdata[CFG_DIR_BIT])))
		else $error("per-pin direction not shared with orientation");

	AST_RESET_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) |-> ((pin_out == RST_DRIVE) && (pin_oe == RST_ORIENT)
		&& (cfg.sampled == RST_SAMPLED)))
		else $error("registers not zero after reset");

	// ----------------------------------------------------------------
	// bus timing and read-back checks
	// ----------------------------------------------------------------
	sequence s_rd_any;
		hsel && (htrans == HTRANS_NONSEQ) && hready && !hwrite;
	endsequence

	sequence s_wr_any;
		hsel && (htrans == HTRANS_NONSEQ) && hready && hwrite;
	endsequence

	// reads always pay one wait state, writes none
	sequence s_wait_then_data;
		!hreadyout ##1 hreadyout;
	endsequence

	AST_READ_ONE_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
		s_rd_any |=> s_wait_then_data)
		else $error("read did not take exactly one wait state");

	AST_WRITE_NO_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr_any |=> hreadyout)
		else $error("write data phase was stretched");

	AST_RESP_OKAY: assert property (@(posedge hclk) disable iff (!hresetn)
		hresp == HRESP_OKAY)
		else $error("response other than okay");

	AST_DRIVE_READ: assert property (@(posedge hclk) disable iff (!hresetn)
		s_rd(OFF_DRIVE) |-> ##2 (hrdata == pin_out))
		else $error("drive level read wrong");

	AST_ORIENT_READ: assert property (@(posedge hclk) disable iff (!hresetn)
		s_rd(OFF_ORIENT) |-> ##2 (hrdata == pin_oe))
		else $error("orientation read wrong");

	AST_SAMPLED_READ: assert property (@(posedge hclk) disable iff (!hresetn)
		s_rd(OFF_SAMPLED) |-> ##2 (hrdata == $past(cfg.sampled)))
		else $error("sampled level read wrong");

	// read-only word: a write must touch neither pin register
	AST_SAMPLED_WRITE_IGNORED: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wr_done(OFF_SAMPLED) |=> ($stable(pin_out) && $stable(pin_oe)))
		else $error("write to sampled level changed a register");

	AST_DRIVE_HOLDS: assert property (@(posedge hclk) disable iff (!hresetn)
		(st_r.ph != GPLD_PH_WRITE) |=> $stable(pin_out))
		else $error("drive level moved without a write");

	AST_ORIENT_HOLDS: assert property (@(posedge hclk) disable iff (!hresetn)
		(st_r.ph != GPLD_PH_WRITE) |=> $stable(pin_oe))
		else $error("orientation moved without a write");

	AST_DRIVE_ALIAS_KEEPS_ORIENT: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_wr_done(OFF_DRIVE_SET) or s_wr_done(OFF_DRIVE_CLR)) |=> $stable(pin_oe))
		else $error("drive alias write changed orientation");

	AST_ORIENT_ALIAS_KEEPS_DRIVE: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_wr_done(OFF_ORIENT_SET) or s_wr_done(OFF_ORIENT_CLR)) |=> $stable(pin_out))
		else $error("orientation alias write changed drive level");

	// address still held in the wait state, so the pin index is current
	AST_CFG_READ: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_rd_any and is_cfg(haddr[11:0])) |-> ##2 (hrdata[31:2] == 30'h0000_0000)
		&& (hrdata[CFG_DIR_BIT] == pin_oe[st_r.addr[6:2]]))
		else $error("per-pin direction read wrong");

	AST_RESET_BUS: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) |-> (hreadyout && (hrdata == RST_RDATA) && (hresp == HRESP_OKAY)))
		else $error("bus outputs not idle after reset");

endmodule // gpld_port

/* File: verification/gpld_port_bench.sv */
// self-checking bench for the 32-pin port core, driven over AHB-Lite
// assumes gpld_pkg is compiled first and hready is fed from hreadyout
module gpld_port_bench
	import gpld_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] pin_in = 32'h0000_0000;
	logic hreadyout;
	logic [31:0] hrdata;
	logic hresp;
	logic [31:0] pin_out;
	logic [31:0] pin_oe;
	int err_count = 0;
	int tests_run = 0;
	logic [31:0] drv;
	logic [31:0] ori;

	always #12.5 hclk = ~hclk;

	gpld_port u_gpld_port (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hreadyout(hreadyout),
		.hrdata(hrdata),
		.hresp(hresp),
		.pin_in(pin_in),
		.pin_out(pin_out),
		.pin_oe(pin_oe)
	);

	// ----------------------------------------------------------------
	// bus and compare tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// values seen just after the edge are the pre-edge ones
	task automatic bus_wait;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			check("hready", {31'h0, hreadyout}, 32'h0000_0001);
		end
	endtask

	// called right after a rising edge; ends at the edge closing the data phase
	task automatic xfer(input logic wr, input logic [11:0] off, input logic [31:0] wd,
			output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {20'h0_0000, off};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= 3'h2;
		bus_wait();
		htrans <= 2'h0;
		hwdata <= wd;
		bus_wait();
		rd = hrdata;
	endtask

	task automatic wr(input logic [11:0] off, input logic [31:0] d);
		logic [31:0] dummy;
		xfer(1'b1, off, d, dummy);
	endtask

	task automatic rd_chk(input logic [11:0] off, input logic [31:0] exp);
		logic [31:0] v;
		xfer(1'b0, off, 32'h0000_0000, v);
		check($sformatf("read %h", off), v, exp);
	endtask

	// pins settle at the edge that closes the write data phase
	task automatic pin_chk(input logic [31:0] eo, input logic [31:0] ee);
		@(negedge hclk);
		check("pin_out", pin_out, eo);
		check("pin_oe", pin_oe, ee);
		@(posedge hclk);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// watchdog: the whole sequence needs about 125 cycles
	// ----------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge hclk);
		err_count++;
		tally_and_finish();
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		logic [11:0] offs [7];
		offs = '{OFF_DRIVE, OFF_DRIVE_SET, OFF_DRIVE_CLR, OFF_SAMPLED, OFF_ORIENT,
			OFF_ORIENT_SET, OFF_ORIENT_CLR};
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (offs[i]) rd_chk(offs[i], 32'h0000_0000);
		pin_chk(32'h0000_0000, 32'h0000_0000);
		$display("test reset done");

		drv = 32'ha5a5_5a5a;
		wr(OFF_DRIVE, drv);
		pin_chk(drv, 32'h0000_0000);
		rd_chk(OFF_DRIVE_SET, drv);
		rd_chk(OFF_DRIVE_CLR, drv);
		rd_chk(OFF_DRIVE, drv);
		wr(OFF_DRIVE_SET, 32'h0000_00ff);
		drv = drv | 32'h0000_00ff;
		pin_chk(drv, 32'h0000_0000);
		wr(OFF_DRIVE_SET, 32'h0000_0000);
		pin_chk(drv, 32'h0000_0000);
		wr(OFF_DRIVE_CLR, 32'hf000_000f);
		drv = drv & ~32'hf000_000f;
		rd_chk(OFF_DRIVE, drv);
		pin_chk(drv, 32'h0000_0000);
		$display("test drive done");

		ori = 32'h0f0f_0f0f;
		wr(OFF_ORIENT, ori);
		pin_chk(drv, ori);
		rd_chk(OFF_ORIENT_SET, ori);
		rd_chk(OFF_ORIENT_CLR, ori);
		wr(OFF_ORIENT_SET, 32'h3000_0000);
		ori = ori | 32'h3000_0000;
		pin_chk(drv, ori);
		wr(OFF_ORIENT_CLR, 32'h0000_0f01);
		ori = ori & ~32'h0000_0f01;
		pin_chk(drv, ori);
		$display("test orientation done");

		// pin 5 becomes an output with its input buffer connected
		wr(OFF_CFG_BASE + 12'h014, 32'h0000_0001);
		ori = ori | 32'h0000_0020;
		pin_chk(drv, ori);
		rd_chk(OFF_ORIENT, ori);
		rd_chk(OFF_CFG_BASE + 12'h014, 32'h0000_0001);
		wr(OFF_ORIENT_CLR, 32'h0000_0020);
		ori = ori & ~32'h0000_0020;
		rd_chk(OFF_CFG_BASE + 12'h014, 32'h0000_0000);
		$display("test per pin config done");

		pin_in <= 32'h8000_0021;
		repeat (4) @(posedge hclk);
		rd_chk(OFF_SAMPLED, 32'h0000_0020);
		wr(OFF_CFG_BASE, 32'h0000_0000);
		rd_chk(OFF_SAMPLED, 32'h0000_0021);
		wr(OFF_SAMPLED, 32'hffff_ffff);
		rd_chk(OFF_SAMPLED, 32'h0000_0021);
		pin_in <= 32'h0000_0001;
		repeat (4) @(posedge hclk);
		rd_chk(OFF_SAMPLED, 32'h0000_0001);
		$display("test sampled level done");

		wr(12'h600, 32'hffff_ffff);
		rd_chk(12'h600, 32'h0000_0000);
		rd_chk(OFF_DRIVE, drv);
		rd_chk(OFF_ORIENT, ori);
		check("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
		$display("test unmapped done");

		// second reset with pins driven and connected
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		rd_chk(OFF_DRIVE, 32'h0000_0000);
		rd_chk(OFF_ORIENT, 32'h0000_0000);
		rd_chk(OFF_SAMPLED, 32'h0000_0000);
		pin_chk(32'h0000_0000, 32'h0000_0000);
		$display("test second reset done");
		tally_and_finish();
	end
endmodule // gpld_port_bench
